// ==== hdl/sll_lane.sv ====
// Purpose: one receive lane: framing lock, configuration checksum, end character substitution
// Assumes: octets arrive one per clock with i_valid, already code-group aligned
// Notes: held idle while the receiver core is in soft reset
module sll_lane
	import sll_pkg::*;
(
	input wire logic i_clock, // system clock
	input wire logic i_reset, // async reset, active high
	input wire logic i_core_reset, // receiver core soft reset
	input wire logic i_subst_off, // end character substitution off
	input wire logic i_cgs, // code group sync for this lane
	input wire logic i_valid, // octet strobe
	input wire logic [7:0] i_data, // received octet
	input wire logic i_is_k, // octet is a control character
	output logic o_framing_lock, // framing lock flag
	output logic o_checksum_ok, // checksum result flag
	output logic o_valid, // output octet strobe
	output logic [7:0] o_data // octet after substitution
);
	sll_state_e state_q;
	logic [3:0] idx_q;
	logic [7:0] sum_q;
	logic [7:0] last_q;
	logic lock_q;
	logic cks_q;
	logic end_char;

	assign end_char = i_is_k && (i_data == SLL_K_MF_END || i_data == SLL_K_FRAME_END);
	assign o_framing_lock = lock_q;
	assign o_checksum_ok = cks_q;

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			state_q <= SLL_ST_WAIT_SYNC;
		else if (i_core_reset || !i_cgs)
			state_q <= SLL_ST_WAIT_SYNC;
		else if (i_valid)
		begin
			case (state_q)
				SLL_ST_WAIT_SYNC:
					if (!(i_is_k && i_data == SLL_K_SYNC))
						state_q <= SLL_ST_WAIT_CFG;
				SLL_ST_WAIT_CFG:
					if (i_is_k && i_data == SLL_K_CONFIG_START)
						state_q <= SLL_ST_CONFIG;
				SLL_ST_CONFIG:
					if (idx_q == SLL_CFG_LAST)
						state_q <= SLL_ST_DATA;
				default:
					state_q <= state_q;
			endcase
		end
	end

	// lock on the first octet after the sync characters end; drop with sync loss
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			lock_q <= 1'b0;
		else if (i_core_reset || !i_cgs)
			lock_q <= 1'b0;
		else if (i_valid && state_q == SLL_ST_WAIT_SYNC && !(i_is_k && i_data == SLL_K_SYNC))
			lock_q <= 1'b1;
	end

	// configuration octets 0..12 are summed mod 256, octet 13 carries the sent sum
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
		begin
			idx_q <= SLL_CFG_ZERO;
			sum_q <= SLL_RESET_FLAGS;
		end
		else if (state_q != SLL_ST_CONFIG)
		begin
			idx_q <= SLL_CFG_ZERO;
			sum_q <= SLL_RESET_FLAGS;
		end
		else if (i_valid)
		begin
			idx_q <= idx_q + SLL_CFG_ONE;
			sum_q <= sum_q + i_data;
		end
	end

	// result survives sync loss and is kept until the next alignment sequence or a soft reset, so software can read it late
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			cks_q <= 1'b0;
		else if (i_core_reset)
			cks_q <= 1'b0;
		else if (i_valid && i_cgs && state_q == SLL_ST_CONFIG && idx_q == SLL_CFG_LAST)
			cks_q <= (sum_q == i_data);
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_valid <= 1'b0;
			o_data <= SLL_RESET_FLAGS;
			last_q <= SLL_RESET_FLAGS;
		end
		else
		begin
			// an octet met with sync low or soft reset is not taken, so it is never passed on
			o_valid <= i_valid && i_cgs && !i_core_reset && state_q == SLL_ST_DATA;
			if (i_valid)
			begin
				// substitution only in user data; alignment sequence passes untouched
				if (state_q == SLL_ST_DATA && end_char && !i_subst_off)
					o_data <= last_q;
				else
					o_data <= i_data;
				if (!(end_char && !i_subst_off))
					last_q <= i_data;
			end
		end
	end
endmodule : sll_lane

// ==== hdl/sll_link_status.sv ====
// Purpose: per-lane link status flags and receiver link control registers
// Assumes: register port is the device's internal serial-interface register access
// Notes: read data appears one clock after the read strobe
module sll_link_status
	import sll_pkg::*;
#(
	parameter int LANES = SLL_LANES // lanes fitted
)
(
	input wire logic i_clock, // system clock 50 MHz
	input wire logic i_reset, // async reset, active high
	input wire logic [11:0] i_reg_addr, // register address
	input wire logic i_reg_wr, // write strobe
	input wire logic i_reg_rd, // read strobe
	input wire logic [7:0] i_reg_wdata, // write data
	output logic [7:0] o_reg_rdata, // read data, registered
	input wire logic [LANES-1:0] i_lane_cgs, // code group sync per lane
	input wire logic [LANES-1:0] i_lane_valid, // octet strobe per lane
	input wire logic [LANES*8-1:0] i_lane_data, // octets, lane n at [8n+7:8n]
	input wire logic [LANES-1:0] i_lane_is_k, // control character flag per lane
	output logic [LANES-1:0] o_lane_valid, // output octet strobe per lane
	output logic [LANES*8-1:0] o_lane_data, // octets after substitution
	output logic o_core_reset // receiver core soft reset level
);
	logic [7:0] soft_q;
	logic [7:0] ctrl_q;
	logic [LANES-1:0] lock;
	logic [LANES-1:0] cks;
	logic [7:0] lock_flags;
	logic [7:0] cks_flags;
	logic core_reset;
	logic subst_off;

	assign core_reset = soft_q[SLL_BIT_CORE_RESET];
	assign subst_off = ctrl_q[SLL_BIT_SUBST_OFF];
	assign o_core_reset = core_reset;

	for (genvar n = 0; n < LANES; n++)
	begin : g_lane
		sll_lane u_lane (
			.i_clock(i_clock),
			.i_reset(i_reset),
			.i_core_reset(core_reset),
			.i_subst_off(subst_off),
			.i_cgs(i_lane_cgs[n]),
			.i_valid(i_lane_valid[n]),
			.i_data(i_lane_data[n*8 +: 8]),
			.i_is_k(i_lane_is_k[n]),
			.o_framing_lock(lock[n]),
			.o_checksum_ok(cks[n]),
			.o_valid(o_lane_valid[n]),
			.o_data(o_lane_data[n*8 +: 8])
		);
	end

	// unfitted lanes read as zero
	always_comb
	begin
		lock_flags = SLL_RESET_FLAGS;
		cks_flags = SLL_RESET_FLAGS;
		lock_flags[LANES-1:0] = lock;
		cks_flags[LANES-1:0] = cks;
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			soft_q <= SLL_RESET_SOFT;
		else if (i_reg_wr && i_reg_addr == SLL_ADDR_SOFT_RESET)
			soft_q <= i_reg_wdata;
	end

	// writes outside soft reset are dropped so the lanes never see a mid-frame change
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			ctrl_q <= SLL_RESET_CTRL;
		else if (i_reg_wr && i_reg_addr == SLL_ADDR_LINK_CTRL && core_reset)
			ctrl_q <= i_reg_wdata;
	end

	// status registers have no write path
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			o_reg_rdata <= SLL_READ_ZERO;
		else if (i_reg_rd)
		begin
			if (i_reg_addr == SLL_ADDR_FRAMING_LOCK)
				o_reg_rdata <= lock_flags;
			else if (i_reg_addr == SLL_ADDR_CHECKSUM_OK)
				o_reg_rdata <= cks_flags;
			else if (i_reg_addr == SLL_ADDR_SOFT_RESET)
				o_reg_rdata <= soft_q;
			else if (i_reg_addr == SLL_ADDR_LINK_CTRL)
				o_reg_rdata <= ctrl_q;
			else
				o_reg_rdata <= SLL_READ_ZERO;
		end
	end
endmodule : sll_link_status

// ==== hdl/sll_pkg.sv ====
// Purpose: shared constants for the serial lane link status block
// Assumes: 8-bit register port, 8b/10b decoded octets per lane
// Notes: control character codes are the decoded K values
package sll_pkg;
	localparam int SLL_LANES = 8;
	localparam logic [11:0] SLL_ADDR_FRAMING_LOCK = 12'h471;
	localparam logic [11:0] SLL_ADDR_CHECKSUM_OK = 12'h472;
	localparam logic [11:0] SLL_ADDR_SOFT_RESET = 12'h475;
	localparam logic [11:0] SLL_ADDR_LINK_CTRL = 12'h476;
	localparam int SLL_BIT_CORE_RESET = 3;
	localparam int SLL_BIT_SUBST_OFF = 6;
	localparam logic [7:0] SLL_RESET_FLAGS = 8'h00;
	localparam logic [7:0] SLL_RESET_SOFT = 8'h00;
	localparam logic [7:0] SLL_RESET_CTRL = 8'h00;
	localparam logic [7:0] SLL_READ_ZERO = 8'h00;
	localparam logic [7:0] SLL_K_SYNC = 8'hbc;
	localparam logic [7:0] SLL_K_CONFIG_START = 8'h9c;
	localparam logic [7:0] SLL_K_MF_END = 8'h7c;
	localparam logic [7:0] SLL_K_FRAME_END = 8'hfc;
	localparam logic [3:0] SLL_CFG_LAST = 4'hd;
	localparam logic [3:0] SLL_CFG_ZERO = 4'h0;
	localparam logic [3:0] SLL_CFG_ONE = 4'h1;

	typedef enum logic [3:0] {
		SLL_ST_WAIT_SYNC = 4'b0001,
		SLL_ST_WAIT_CFG = 4'b0010,
		SLL_ST_CONFIG = 4'b0100,
		SLL_ST_DATA = 4'b1000
	} sll_state_e;
endpackage : sll_pkg

// ==== tb/sll_link_status_checker.sv ====
// Purpose: port checks for the lane link status block
// Assumes: lane 0 stands for all lanes on the data path
// Notes: mirrors the substitution-off bit from register writes
module sll_link_status_checker
	import sll_pkg::*;
#(
	parameter int LANES = SLL_LANES // lanes fitted
)
(
	input wire logic i_clock, // clock
	input wire logic i_reset, // reset
	input wire logic [11:0] i_reg_addr, // address
	input wire logic i_reg_wr, // write
	input wire logic i_reg_rd, // read
	input wire logic [7:0] i_reg_wdata, // write data
	input wire logic [7:0] o_reg_rdata, // read data
	input wire logic [LANES-1:0] i_lane_cgs, // sync
	input wire logic [LANES-1:0] i_lane_valid, // strobe in
	input wire logic [LANES*8-1:0] i_lane_data, // octets in
	input wire logic [LANES-1:0] i_lane_is_k, // control flag
	input wire logic [LANES-1:0] o_lane_valid, // strobe out
	input wire logic [LANES*8-1:0] o_lane_data, // octets out
	input wire logic o_core_reset // soft reset
);
	timeunit 1ns;
	timeprecision 1ps;
	logic subst_off_q;
	logic ctrl_wr;
	assign ctrl_wr = i_reg_wr && i_reg_addr == SLL_ADDR_LINK_CTRL && o_core_reset;
	always_ff @(posedge i_clock or posedge i_reset)
		if (i_reset)
			subst_off_q <= 1'b0;
		else if (ctrl_wr)
			subst_off_q <= i_reg_wdata[SLL_BIT_SUBST_OFF];
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	soft_follow_a: assert property ($past(i_reg_wr && i_reg_addr == SLL_ADDR_SOFT_RESET) |->
		o_core_reset == $past(i_reg_wdata[SLL_BIT_CORE_RESET])) else $error("soft reset bit");
	flags_clear_a: assert property (i_reg_rd && (i_reg_addr == SLL_ADDR_FRAMING_LOCK ||
		i_reg_addr == SLL_ADDR_CHECKSUM_OK) && o_core_reset && $past(o_core_reset)
		|=> o_reg_rdata == SLL_RESET_FLAGS) else $error("flags not clear");
	rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
	lanes_idle_a: assert property (o_core_reset |=> o_lane_valid == '0) else $error("lane active");
	valid_cause_a: assert property (o_lane_valid[0] |-> $past(i_lane_valid[0] && i_lane_cgs[0]))
		else $error("stray strobe");
	end_replace_a: assert property (!subst_off_q && o_lane_valid[0] &&
		$past(i_lane_is_k[0] && (i_lane_data[7:0] == SLL_K_MF_END ||
		i_lane_data[7:0] == SLL_K_FRAME_END)) |-> o_lane_data[7:0] != $past(i_lane_data[7:0]))
		else $error("end char kept");
	end_keep_a: assert property (subst_off_q && o_lane_valid[0] |->
		o_lane_data[7:0] == $past(i_lane_data[7:0])) else $error("octet altered");
	cover property (o_core_reset);
	cover property (subst_off_q && o_lane_valid[0]);
	cover property (!subst_off_q && o_lane_valid[0] && $past(i_lane_is_k[0]));
endmodule : sll_link_status_checker

// ==== tb/sll_tx_model.sv ====
// Purpose: transmitter model sending sync, alignment start, config and data
// Assumes: every lane carries the same stream, except the spoiled checksum octet on lanes set in i_bad
// Notes: released data lines toggle so stale values never look valid
module sll_tx_model
	import sll_pkg::*;
(
	input wire logic i_clock, // bench clock
	input wire logic i_go, // send while high
	input wire logic [7:0] i_bad, // lanes with a spoiled checksum octet
	output logic [7:0] o_valid, // strobe
	output logic [7:0] o_cgs, // sync
	output logic [7:0] o_is_k, // control flag
	output logic [63:0] o_data = '0 // octets
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	logic [7:0] b;
	always @(negedge i_clock)
	begin
		n = i_go ? n + 1 : 0;
		b = n < 3 ? SLL_K_SYNC : n == 3 ? 8'h1c : n == 4 ? SLL_K_CONFIG_START : n < 18 ? 8'(n - 4)
			: n == 18 ? 8'h5b : n % 8 == 0 ? SLL_K_MF_END : n % 4 == 0 ? SLL_K_FRAME_END : 8'(n);
		o_is_k = {8{i_go && (n < 5 || n > 18 && n % 4 == 0)}};
		o_cgs = {8{i_go}};
		o_valid = {8{i_go}};
		for (int l = 0; l < 8; l++)
			o_data[8*l +: 8] = i_go ? b ^ {7'h0, n == 18 && i_bad[l]} : ~o_data[8*l +: 8];
	end
endmodule : sll_tx_model

// ==== tb/tb_sll_link_status.sv ====
// Purpose: bench for the lane link status block
// Assumes: model restarts its sequence whenever go rises
// Notes: flags are judged through register reads only
module tb_sll_link_status
	import sll_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 0, i_reset = 1, i_reg_wr = 0, i_reg_rd = 0, go = 0;
	logic [11:0] i_reg_addr = '0;
	logic [7:0] i_reg_wdata = '0, bad = '0, o_reg_rdata, i_lane_cgs, i_lane_valid, i_lane_is_k;
	logic [7:0] o_lane_valid;
	logic [63:0] i_lane_data, o_lane_data;
	logic o_core_reset;
	int num_errors = 0, total_checks = 0, cycles = 0;
	sll_tx_model tx_u (.i_clock, .i_go(go), .i_bad(bad), .o_valid(i_lane_valid),
		.o_cgs(i_lane_cgs), .o_is_k(i_lane_is_k), .o_data(i_lane_data));
	sll_link_status dut_u (.i_clock, .i_reset, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
		.o_reg_rdata, .i_lane_cgs, .i_lane_valid, .i_lane_data, .i_lane_is_k, .o_lane_valid,
		.o_lane_data, .o_core_reset);
	always #10 i_clock = ~i_clock;
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	task automatic check(input logic [7:0] seen, input logic [7:0] want, input logic [11:0] a);
		total_checks++;
		if (seen !== want)
		begin
			num_errors++;
			$display("[ERR] %0t read %h got %h want %h", $time, a, seen, want);
		end
	endtask : check
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge i_clock);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1;
		@(negedge i_clock);
		i_reg_wr = 0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(negedge i_clock);
		i_reg_addr = a;
		i_reg_rd = 1;
		@(negedge i_clock);
		i_reg_rd = 0;
		@(negedge i_clock);
		check(o_reg_rdata, e, a);
	endtask : rd
	task automatic s_reset_values();
		rd(SLL_ADDR_FRAMING_LOCK, 8'h00);
		wr(SLL_ADDR_CHECKSUM_OK, 8'hff);
		rd(SLL_ADDR_CHECKSUM_OK, 8'h00);
		rd(12'h400, SLL_READ_ZERO);
	endtask : s_reset_values
	task automatic s_link(input logic [7:0] m);
		bad = m;
		// model always sends the full alignment sequence, so the flags carry meaning
		@(negedge i_clock) go <= 1;
		repeat (30) @(negedge i_clock);
		rd(SLL_ADDR_FRAMING_LOCK, 8'hff);
		rd(SLL_ADDR_CHECKSUM_OK, ~m);
	endtask : s_link
	task automatic s_soft_subst();
		wr(SLL_ADDR_SOFT_RESET, 8'h08);
		rd(SLL_ADDR_FRAMING_LOCK, 8'h00);
		rd(SLL_ADDR_CHECKSUM_OK, 8'h00);
		wr(SLL_ADDR_LINK_CTRL, 8'h40);
		go <= 0;
		wr(SLL_ADDR_SOFT_RESET, 8'h00);
		s_link(8'h00);
		wr(SLL_ADDR_LINK_CTRL, 8'h00);
		rd(SLL_ADDR_LINK_CTRL, 8'h40);
		go <= 0;
		// let sync loss reach the lanes before the flag is read
		repeat (3) @(negedge i_clock);
		rd(SLL_ADDR_FRAMING_LOCK, 8'h00);
		rd(SLL_ADDR_CHECKSUM_OK, 8'hff);
	endtask : s_soft_subst
	initial
	begin
		repeat (16) @(posedge i_clock);
		@(negedge i_clock) i_reset = 0;
		s_reset_values();
		s_link(8'h0a);
		s_soft_subst();
		wrap_up();
	end
endmodule : tb_sll_link_status
bind sll_link_status sll_link_status_checker #(.LANES(LANES)) chk_u (.i_clock, .i_reset,
	.i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_lane_cgs, .i_lane_valid,
	.i_lane_data, .i_lane_is_k, .o_lane_valid, .o_lane_data, .o_core_reset);
